// ===== src/seq_pkg.sv
// constants shared by the slew, sequencing and voltage-select logic
// Overview of operation
// - ramp buck_2 and buck_3 at programmed slew
// - follow bit applies same slew to linear_reg_b
// - vsel pin edge starts the ramp
// - setting register write starts ramp at once
// - slew codes 0..6 rates, code 7 immediate
// - bits 7..5 pick order, all drop together at OFF
// - code 000 enables both on entering ON
// - code 001 waits buck_3 enabled and ok
// - code 010 ext pin, linear_reg_b 1ms later
// - code 010 OFF drops ext pin with linear_reg_b
// - code 011 linear_reg_a 300us after buck_1 ok
// - code 100 a after buck_1 ok, b with buck_3
// - code 101 a with buck_2, b after buck_1 ok
// - code 110 a 10ms after buck_2 ok
// - code 111 ext pin, b 1ms, a on pin
// - code 111 sleep drops a, shutdown drops b
// - sequencing updates enable bits, software may override
// - delays count from previous rail output_ok; the 1ms linear_reg_b delays count from the ext pin
// - every linear enable delayed 170us internally
// - linear_reg_a 4-bit voltage code table
// - follow bit picks own field or buck_3 setting
// - linear_reg_b 6-bit code uses buck_3 table
// - buck_3 target from low or high by pin
// - undervoltage lockout reloads register defaults
package seq_pkg;
   // register offsets
   localparam logic [7:0] ADDR_SLEW  = 8'h15;
   localparam logic [7:0] ADDR_LIN_A = 8'h16;
   localparam logic [7:0] ADDR_LIN_B = 8'h17;
   // reset values and writable-bit masks
   localparam logic [7:0] SLEW_RESET  = 8'h06;
   localparam logic [7:0] LIN_A_RESET = 8'h00;
   localparam logic [7:0] LIN_B_RESET = 8'h00;
   localparam logic [7:0] SLEW_MASK   = 8'h07;
   localparam logic [7:0] LIN_A_MASK  = 8'hef;
   localparam logic [7:0] LIN_B_MASK  = 8'h7f;
   // field positions
   localparam int SEQ_LSB    = 5;
   localparam int SEQ_MSB    = 7;
   localparam int FOLLOW_BIT = 6;
   localparam int LIN_A_MSB  = 3;
   localparam int LIN_B_MSB  = 5;
   localparam logic [2:0] SLEW_IMMEDIATE = 3'h7;
   // sequencing codes
   localparam logic [2:0] SEQ_AT_ON      = 3'h0;
   localparam logic [2:0] SEQ_AFTER_B3   = 3'h1;
   localparam logic [2:0] SEQ_EXT_FIRST  = 3'h2;
   localparam logic [2:0] SEQ_B1_SHORT   = 3'h3;
   localparam logic [2:0] SEQ_B1_B3      = 3'h4;
   localparam logic [2:0] SEQ_B2_B1      = 3'h5;
   localparam logic [2:0] SEQ_B2_LONG    = 3'h6;
   localparam logic [2:0] SEQ_EXT_SLEEP  = 3'h7;
   // timing
   localparam int CLK_PERIOD_NS       = 50;
   localparam int EXT_DELAY_US        = 1000;
   localparam int LIN_A_SHORT_US      = 300;
   localparam int LIN_A_LONG_US       = 10000;
   localparam int LIN_ENABLE_DELAY_US = 170;
   // "more than 1ms" gets one extra cycle
   localparam int EXT_DELAY_CYCLES    = EXT_DELAY_US * 1000 / CLK_PERIOD_NS + 1;
   localparam int LIN_A_SHORT_CYCLES  = LIN_A_SHORT_US * 1000 / CLK_PERIOD_NS;
   localparam int LIN_A_LONG_CYCLES   = LIN_A_LONG_US * 1000 / CLK_PERIOD_NS;
   localparam int LIN_EN_DELAY_CYCLES = LIN_ENABLE_DELAY_US * 1000 / CLK_PERIOD_NS;
   localparam int TIMER_W             = 18;
   // slew: one code step is 25 mV in the lower table range
   localparam int STEP_UV  = 25000;
   localparam int STEP_W   = 14;
   localparam int RAIL_NUM = 3;
   // slew rates in uV per us for codes 0..6
   function automatic int slew_rate_uv(input logic [2:0] code);
      case (code)
         3'h0:    slew_rate_uv = 110;
         3'h1:    slew_rate_uv = 220;
         3'h2:    slew_rate_uv = 450;
         3'h3:    slew_rate_uv = 900;
         3'h4:    slew_rate_uv = 1800;
         3'h5:    slew_rate_uv = 3600;
         default: slew_rate_uv = 7200;
      endcase
   endfunction
   // cycles per 25 mV step, rounded down so the rate is never slower than set
   function automatic int slew_step_cycles(input logic [2:0] code);
      slew_step_cycles = STEP_UV * 1000 / slew_rate_uv(code) / CLK_PERIOD_NS;
   endfunction
endpackage

// ===== src/delay_timer.sv
// saturating delay counter: done rises limit+1 cycles after go, drops with go
`timescale 1ns/10ps
module delay_timer
   import seq_pkg::*;
(
   input  wire logic               ref_clk,
   input  wire logic               rstn,
   input  wire logic               go,
   input  wire logic [TIMER_W-1:0] limit,
   output logic                    done
);
   typedef struct packed {
      logic [TIMER_W-1:0] count;
      logic               done;
   } timer_state_t;

   timer_state_t st;
   timer_state_t next_st;

   // count while go stands; a dropped go restarts the wait from zero
   always_comb begin
      next_st = st;
      if (!go) begin
         next_st.count = '0;
         next_st.done  = 1'b0;
      end else if (st.count >= limit) begin
         next_st.done = 1'b1;
      end else begin
         next_st.count = st.count + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign done = st.done;
endmodule

// ===== src/ramp_channel.sv
// steps one rail's voltage code toward its target at the programmed rate
`timescale 1ns/10ps
module ramp_channel
   import seq_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              rstn,
   input  wire logic [5:0]        target,
   input  wire logic [STEP_W-1:0] stepCycles,
   input  wire logic              immediate,
   input  wire logic              running,
   output logic [5:0]             level,
   output logic                   busy
);
   typedef struct packed {
      logic [5:0]        level;
      logic [STEP_W:0]   count;
   } ramp_state_t;

   ramp_state_t st;
   ramp_state_t next_st;
   logic [STEP_W:0] stepLimit;

   // codes from 32 up are 50 mV apart, so such a step takes twice as long
   assign stepLimit = (st.level >= 6'h20) ? {stepCycles, 1'b0} : {1'b0, stepCycles};

   always_comb begin
      next_st = st;
      if (!running || immediate) begin
         next_st.level = target;
         next_st.count = '0;
      end else if (st.level != target) begin
         if (st.count + 1'b1 >= stepLimit) begin
            next_st.count = '0;
            next_st.level = (target > st.level) ? st.level + 6'h01 : st.level - 6'h01;
         end else begin
            next_st.count = st.count + 1'b1;
         end
      end else begin
         next_st.count = '0;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign level = st.level;
   assign busy  = (st.level != target);
endmodule

// ===== src/regulator_slew_and_ldo_sequencer.sv
// slew control, linear regulator sequencing and voltage selection
`timescale 1ns/10ps
module regulator_slew_and_ldo_sequencer
   import seq_pkg::*;
#(
   parameter int SLOWEST_STEP_CYCLES = slew_step_cycles(3'h0),
   parameter int EXT_DELAY           = EXT_DELAY_CYCLES,
   parameter int LIN_A_SHORT_DELAY   = LIN_A_SHORT_CYCLES,
   parameter int LIN_A_LONG_DELAY    = LIN_A_LONG_CYCLES
)
(
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   input  wire logic       undervoltageLockout,
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWrEn,
   input  wire logic       regRdEn,
   output logic [7:0]      regRdData,
   input  wire logic [5:0] buck2LowSetting,
   input  wire logic [5:0] buck2HighSetting,
   input  wire logic [5:0] buck3LowSetting,
   input  wire logic [5:0] buck3HighSetting,
   input  wire logic       buck2VselPin,
   input  wire logic       buck3VselPin,
   input  wire logic       buck3EnablePin,
   input  wire logic       deviceOn,
   input  wire logic       buck1Enabled,
   input  wire logic       buck2Enabled,
   input  wire logic       buck3Enabled,
   input  wire logic       buck1OutputOk,
   input  wire logic       buck2OutputOk,
   input  wire logic       buck3OutputOk,
   input  wire logic       swLinearWrEn,
   input  wire logic       swLinearAEnable,
   input  wire logic       swLinearBEnable,
   output logic            linearAEnableBit,
   output logic            linearBEnableBit,
   output logic            linearAEnable,
   output logic            linearBEnable,
   output logic            extRegEnablePin,
   output logic [5:0]      buck2Level,
   output logic [5:0]      buck3Level,
   output logic [5:0]      linearBLevel,
   output logic [3:0]      linearAVoltageCode,
   output logic [2:0]      rampBusy
);
   typedef struct packed {
      logic [2:0] vsel2Sync;
      logic [2:0] vsel3Sync;
      logic [1:0] en3Sync;
      logic [7:0] slewReg;
      logic [7:0] linAReg;
      logic [7:0] linBReg;
      logic [7:0] rdData;
      logic       reqAPrev;
      logic       reqBPrev;
      logic       bitA;
      logic       bitB;
      logic       enA;
      logic       enB;
      logic       ext;
      logic [5:0] lvl2;
      logic [5:0] lvl3;
      logic [5:0] lvlB;
      logic [2:0] busy;
   } top_state_t;

   top_state_t st;
   top_state_t next_st;

   logic [2:0]         seqCode;
   logic               follow;
   logic               vsel2;
   logic               vsel3;
   logic               en3Pin;
   logic [5:0]         target [RAIL_NUM];
   logic [RAIL_NUM-1:0] running;
   logic [5:0]         level  [RAIL_NUM];
   logic [RAIL_NUM-1:0] busy;
   logic [STEP_W-1:0]  stepCycles;
   logic               immediate;
   logic               seqGo;
   logic [TIMER_W-1:0] seqLimit;
   logic               seqDone;
   logic               reqA;
   logic               reqB;
   logic               extReq;
   logic               delayADone;
   logic               delayBDone;

   assign seqCode   = st.linAReg[SEQ_MSB:SEQ_LSB];
   assign follow    = st.linBReg[FOLLOW_BIT];
   // the second synchroniser stage is the only one logic reads
   assign vsel2     = st.vsel2Sync[1];
   assign vsel3     = st.vsel3Sync[1];
   assign en3Pin    = st.en3Sync[1];
   assign immediate = (st.slewReg[2:0] == SLEW_IMMEDIATE);

   // per-step period for the selected rate; code 0 may be shortened in simulation
   always_comb begin
      if (st.slewReg[2:0] == 3'h0) begin
         stepCycles = STEP_W'(SLOWEST_STEP_CYCLES);
      end else begin
         stepCycles = STEP_W'(slew_step_cycles(st.slewReg[2:0]));
      end
   end

   // targets follow the vsel pins and any rewrite of the setting registers at once
   assign target[0] = vsel2 ? buck2HighSetting : buck2LowSetting;
   assign target[1] = vsel3 ? buck3HighSetting : buck3LowSetting;
   assign target[2] = follow ? target[1] : st.linBReg[LIN_B_MSB:0];
   // ramps only while the rail runs; untracked linear_reg_b steps at once
   assign running[0] = buck2Enabled;
   assign running[1] = buck3Enabled;
   assign running[2] = st.enB & follow;

   genvar r;
   generate
      for (r = 0; r < RAIL_NUM; r++) begin : g_rail
         ramp_channel u_ramp (
            .ref_clk    (ref_clk),
            .rstn       (rstn),
            .target     (target[r]),
            .stepCycles (stepCycles),
            .immediate  (immediate),
            .running    (running[r]),
            .level      (level[r]),
            .busy       (busy[r])
         );
      end
   endgenerate

   // one shared timer: only one staggered delay is active in any code
   always_comb begin
      seqGo    = 1'b0;
      seqLimit = '0;
      case (seqCode)
         SEQ_EXT_FIRST, SEQ_EXT_SLEEP: begin
            seqGo    = st.ext;
            seqLimit = TIMER_W'(EXT_DELAY);
         end
         SEQ_B1_SHORT: begin
            seqGo    = deviceOn & buck1OutputOk;
            seqLimit = TIMER_W'(LIN_A_SHORT_DELAY);
         end
         SEQ_B2_LONG: begin
            seqGo    = deviceOn & buck2Enabled & buck2OutputOk;
            seqLimit = TIMER_W'(LIN_A_LONG_DELAY);
         end
         default: begin
            seqGo    = 1'b0;
            seqLimit = '0;
         end
      endcase
   end

   delay_timer u_seq_timer (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .go      (seqGo),
      .limit   (seqLimit),
      .done    (seqDone)
   );

   // power-up requests per order; all fall together when deviceOn drops, so power-down is not staggered
   always_comb begin
      reqA   = 1'b0;
      reqB   = 1'b0;
      extReq = 1'b0;
      if (deviceOn) begin
         case (seqCode)
            SEQ_AT_ON: begin
               reqA = 1'b1;
               reqB = 1'b1;
            end
            SEQ_AFTER_B3: begin
               reqA = buck3Enabled & buck3OutputOk;
               reqB = buck3Enabled & buck3OutputOk;
            end
            SEQ_EXT_FIRST: begin
               extReq = 1'b1;
               reqB   = seqDone;
               reqA   = buck3Enabled;
            end
            SEQ_B1_SHORT: begin
               reqA = seqDone;
            end
            SEQ_B1_B3: begin
               reqA = buck1Enabled & buck1OutputOk;
               reqB = buck3Enabled;
            end
            SEQ_B2_LONG: begin
               reqA = seqDone;
            end
            SEQ_B2_B1: begin
               reqA = buck2Enabled;
               reqB = buck1Enabled & buck1OutputOk;
            end
            default: begin
               extReq = 1'b1;
               reqB   = seqDone & (buck1Enabled | buck2Enabled);
               reqA   = en3Pin & buck3OutputOk;
            end
         endcase
      end
   end

   // the 170us wait lines linear enables up with the bucks' own start delay
   delay_timer u_delay_a (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .go      (st.bitA),
      .limit   (TIMER_W'(LIN_EN_DELAY_CYCLES)),
      .done    (delayADone)
   );

   delay_timer u_delay_b (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .go      (st.bitB),
      .limit   (TIMER_W'(LIN_EN_DELAY_CYCLES)),
      .done    (delayBDone)
   );

   always_comb begin
      next_st = st;
      // pin synchronisers
      next_st.vsel2Sync = {st.vsel2Sync[1:0], buck2VselPin};
      next_st.vsel3Sync = {st.vsel3Sync[1:0], buck3VselPin};
      next_st.en3Sync   = {st.en3Sync[0], buck3EnablePin};

      // register writes keep reserved bits at zero
      if (regWrEn) begin
         if (regAddr == ADDR_SLEW) begin
            next_st.slewReg = regWrData & SLEW_MASK;
         end else if (regAddr == ADDR_LIN_A) begin
            next_st.linAReg = regWrData & LIN_A_MASK;
         end else if (regAddr == ADDR_LIN_B) begin
            next_st.linBReg = regWrData & LIN_B_MASK;
         end
      end
      // lockout wins over a write in the same cycle
      if (undervoltageLockout) begin
         next_st.slewReg = SLEW_RESET;
         next_st.linAReg = LIN_A_RESET;
         next_st.linBReg = LIN_B_RESET;
      end

      // read data; unmapped offsets answer zero
      if (regRdEn) begin
         if (regAddr == ADDR_SLEW) begin
            next_st.rdData = st.slewReg;
         end else if (regAddr == ADDR_LIN_A) begin
            next_st.rdData = st.linAReg;
         end else if (regAddr == ADDR_LIN_B) begin
            next_st.rdData = st.linBReg;
         end else begin
            next_st.rdData = 8'h00;
         end
      end

      // enable bits track sequencer edges, software may change them while on
      next_st.reqAPrev = reqA;
      next_st.reqBPrev = reqB;
      if (swLinearWrEn && deviceOn) begin
         next_st.bitA = swLinearAEnable;
         next_st.bitB = swLinearBEnable;
      end
      // a sequencer edge in the same cycle as a software write wins
      if (reqA != st.reqAPrev) begin
         next_st.bitA = reqA;
      end
      if (reqB != st.reqBPrev) begin
         next_st.bitB = reqB;
      end
      if (!deviceOn) begin
         next_st.bitA = 1'b0;
         next_st.bitB = 1'b0;
      end

      // enables rise 170us after their bit, fall with it
      next_st.enA = st.bitA & delayADone;
      next_st.enB = st.bitB & delayBDone;
      // ext pin depends on the order and ON state only, not on software bits
      next_st.ext = extReq;

      next_st.lvl2 = level[0];
      next_st.lvl3 = level[1];
      next_st.lvlB = level[2];
      next_st.busy = busy;
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st         <= '0;
         st.slewReg <= SLEW_RESET;
         st.linAReg <= LIN_A_RESET;
         st.linBReg <= LIN_B_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign regRdData          = st.rdData;
   assign linearAEnableBit   = st.bitA;
   assign linearBEnableBit   = st.bitB;
   assign linearAEnable      = st.enA;
   assign linearBEnable      = st.enB;
   assign extRegEnablePin    = st.ext;
   assign buck2Level         = st.lvl2;
   assign buck3Level         = st.lvl3;
   assign linearBLevel       = st.lvlB;
   assign linearAVoltageCode = st.linAReg[LIN_A_MSB:0];
   assign rampBusy           = st.busy;
endmodule

// ===== testbench/buck_rail_model.sv
// buck converter model: staggered start with output ok
`timescale 1ns/10ps
module buck_rail_model #(
   parameter int OK_DELAY = 10
)
(
   input  wire logic ref_clk,
   input  wire logic rstn,
   input  wire logic deviceOn,
   input  wire logic buck3EnablePin,
   input  wire logic slow,
   output logic      buck1Enabled,
   output logic      buck2Enabled,
   output logic      buck3Enabled,
   output logic      buck1OutputOk,
   output logic      buck2OutputOk,
   output logic      buck3OutputOk
);
   int cnt;
   int unit;
   // slow mode stretches soft-start so the sequencer waits on output ok
   assign unit = slow ? 4 * OK_DELAY : OK_DELAY;
   // time since the device entered ON, cleared in OFF
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn)
         cnt <= 0;
      else if (!deviceOn)
         cnt <= 0;
      else if (cnt < 1000)
         cnt <= cnt + 1;
   end
   // each rail starts only after the previous one is good; all drop together at OFF
   assign buck1Enabled  = deviceOn;
   assign buck1OutputOk = buck1Enabled && cnt >= unit;
   assign buck2Enabled  = buck1OutputOk;
   assign buck2OutputOk = buck2Enabled && cnt >= 2 * unit;
   assign buck3Enabled  = buck2OutputOk && buck3EnablePin;
   assign buck3OutputOk = buck3Enabled && cnt >= 3 * unit;
endmodule

// ===== testbench/seq_properties.sv
// concurrent checks on the sequencer ports
`timescale 1ns/10ps
module seq_properties
   import seq_pkg::*;
#(
   parameter int EXT_DELAY = EXT_DELAY_CYCLES
)
(
   input wire logic       ref_clk,
   input wire logic       rstn,
   input wire logic       undervoltageLockout,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic       regWrEn,
   input wire logic       regRdEn,
   input wire logic [7:0] regRdData,
   input wire logic [5:0] buck2HighSetting,
   input wire logic [5:0] buck3LowSetting,
   input wire logic       buck2VselPin,
   input wire logic       buck3VselPin,
   input wire logic       deviceOn,
   input wire logic       buck2Enabled,
   input wire logic       swLinearWrEn,
   input wire logic       linearAEnableBit,
   input wire logic       linearBEnableBit,
   input wire logic       linearAEnable,
   input wire logic       extRegEnablePin,
   input wire logic [5:0] buck2Level,
   input wire logic [5:0] buck3Level,
   input wire logic [5:0] linearBLevel
);
   localparam int EN_MAX = LIN_EN_DELAY_CYCLES + 8;
   logic [6:0]  ctl;
   logic [15:0] cntA;
   logic [15:0] cntExt;
   wire  [2:0]  slewCode = ctl[6:4];
   wire  [2:0]  seqCode  = ctl[3:1];
   wire         follow   = ctl[0];
   default clocking dc @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // shadow of slew, order and follow fields; lockout reloads them like the device
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn)
         ctl <= 7'h60;
      else if (undervoltageLockout)
         ctl <= 7'h60;
      else if (regWrEn && regAddr == ADDR_SLEW)
         ctl[6:4] <= regWrData[2:0];
      else if (regWrEn && regAddr == ADDR_LIN_A)
         ctl[3:1] <= regWrData[7:5];
      else if (regWrEn && regAddr == ADDR_LIN_B)
         ctl[0] <= regWrData[FOLLOW_BIT];
   end
   // saturating counts of how long the enable bit and the ext pin have been high
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cntA   <= 16'h0000;
         cntExt <= 16'h0000;
      end else begin
         cntA   <= linearAEnableBit ? cntA + 16'(cntA != 16'hffff) : 16'h0000;
         cntExt <= extRegEnablePin ? cntExt + 16'(cntExt != 16'hffff) : 16'h0000;
      end
   end
   sequence s_b2_steady;
      (slewCode == SLEW_IMMEDIATE && buck2VselPin && $stable(buck2HighSetting)) [*6];
   endsequence
   sequence s_b3_low_steady;
      (slewCode == SLEW_IMMEDIATE && !buck3VselPin && $stable(buck3LowSetting)) [*6];
   endsequence
   a_read_slew: assert property (regRdEn && regAddr == ADDR_SLEW && !regWrEn
      && !undervoltageLockout |=> regRdData == {5'h00, slewCode})
      else $error("slew readback");
   a_unmapped_read: assert property (regRdEn && regAddr > ADDR_LIN_B |=> regRdData == 8'h00)
      else $error("unmapped read");
   a_immediate_level: assert property (s_b2_steady |-> buck2Level == buck2HighSetting)
      else $error("buck2 not immediate");
   a_vsel_low: assert property (s_b3_low_steady |-> buck3Level == buck3LowSetting)
      else $error("buck3 not low setting");
   a_follow_buck3: assert property ((s_b3_low_steady and follow [*6])
      |-> linearBLevel == buck3LowSetting)
      else $error("linear b not tracking");
   a_single_step: assert property (slewCode != SLEW_IMMEDIATE && buck2Enabled
      && $past(buck2Enabled) && $changed(buck2Level) |-> buck2Level == $past(buck2Level)
      + 6'h01 || buck2Level == $past(buck2Level) - 6'h01)
      else $error("buck2 ramp jumped");
   a_at_on_both: assert property (seqCode == SEQ_AT_ON && $rose(deviceOn)
      |=> linearAEnableBit && linearBEnableBit)
      else $error("enables late at ON");
   a_ext_before_b: assert property (seqCode == SEQ_EXT_FIRST && $rose(linearBEnableBit)
      |-> cntExt >= EXT_DELAY)
      else $error("linear b too soon");
   a_ext_drop_b: assert property (seqCode == SEQ_EXT_FIRST && $fell(extRegEnablePin)
      |-> !linearBEnableBit)
      else $error("ext and linear b split");
   a_b_stays_off: assert property (seqCode == SEQ_B1_SHORT && !linearBEnableBit
      && !swLinearWrEn && !regWrEn && !undervoltageLockout |=> !linearBEnableBit)
      else $error("linear b self enabled");
   a_enable_delay: assert property ($rose(linearAEnable) |-> cntA >= LIN_EN_DELAY_CYCLES)
      else $error("linear a early");
   a_enable_late: assert property (linearAEnableBit && cntA == EN_MAX |-> linearAEnable)
      else $error("linear a late");
   a_disable_prompt: assert property ($fell(linearAEnableBit) |=> !linearAEnable)
      else $error("linear a not dropped");
endmodule

// ===== testbench/test_regulator_slew_and_ldo_sequencer.sv
// self-checking bench for the slew and linear regulator sequencer
`timescale 1ns/10ps
module test_regulator_slew_and_ldo_sequencer
   import seq_pkg::*;
;
   localparam int STEP = 20;
   logic       ref_clk = 1'b0;
   logic       rstn, undervoltageLockout, regWrEn, regRdEn, slow;
   logic       swLinearWrEn, swLinearAEnable, swLinearBEnable, deviceOn, buck3EnablePin;
   logic       buck2VselPin, buck3VselPin, buck1Enabled, buck2Enabled, buck3Enabled;
   logic       buck1OutputOk, buck2OutputOk, buck3OutputOk, linearAEnableBit, linearBEnableBit;
   logic       linearAEnable, linearBEnable, extRegEnablePin;
   logic [7:0] regAddr, regWrData, regRdData;
   logic [5:0] buck2LowSetting, buck2HighSetting, buck3LowSetting, buck3HighSetting;
   logic [5:0] buck2Level, buck3Level, linearBLevel;
   logic [3:0] linearAVoltageCode;
   logic [2:0] rampBusy;
   wire  [2:0] trio = {extRegEnablePin, linearAEnableBit, linearBEnableBit};
   int         errors = 0;
   int         nCompared = 0;
   // short counts keep the run small
   regulator_slew_and_ldo_sequencer #(
      .SLOWEST_STEP_CYCLES(STEP),
      .EXT_DELAY(30),
      .LIN_A_SHORT_DELAY(15),
      .LIN_A_LONG_DELAY(40)
   ) DUT (.*);
   buck_rail_model #(.OK_DELAY(10)) rails (.*);
   // 20 MHz clock
   always #25 ref_clk = ~ref_clk;
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      nCompared++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("compared %0d mismatches %0d", nCompared, errors);
      if (errors == 0 && nCompared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      tick(1);
      {regAddr, regWrData, regWrEn} = {a, d, 1'b1};
      tick(1);
      regWrEn = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      tick(1);
      {regAddr, regRdEn} = {a, 1'b1};
      tick(1);
      regRdEn = 1'b0;
      d = regRdData;
   endtask
   task automatic sw_write(input logic a, input logic b);
      tick(1);
      {swLinearAEnable, swLinearBEnable, swLinearWrEn} = {a, b, 1'b1};
      tick(1);
      swLinearWrEn = 1'b0;
      tick(1);
   endtask
   // reset values, reserved bits, unmapped place, lockout reload
   task automatic t_regs();
      logic [7:0] d;
      logic [7:0] a [4] = '{ADDR_SLEW, ADDR_LIN_A, ADDR_LIN_B, 8'h18};
      logic [7:0] m [4] = '{SLEW_MASK, LIN_A_MASK, LIN_B_MASK, 8'h00};
      logic [7:0] r [4] = '{8'h06, LIN_A_RESET, LIN_B_RESET, 8'h00};
      for (int i = 0; i < 4; i++) begin
         rd(a[i], d);
         chk(d, r[i]);
         wr(a[i], 8'hff);
         rd(a[i], d);
         chk(d, m[i]);
         tick(1);
         undervoltageLockout = 1'b1;
         tick(1);
         undervoltageLockout = 1'b0;
         rd(a[i], d);
         chk(d, r[i]);
      end
      wr(ADDR_LIN_A, 8'h0a);
      tick(1);
      chk(linearAVoltageCode, 4'ha);
   endtask
   // immediate code, pin selection, then a slow ramp on a running rail
   task automatic t_slew();
      int n;
      deviceOn     = 1'b1;
      buck2VselPin = 1'b1;
      wr(ADDR_SLEW, 8'h07);
      buck2HighSetting = 6'h1e;
      tick(40);
      chk(buck2Level, 6'h1e);
      buck3VselPin = 1'b1;
      tick(8);
      chk(buck3Level, buck3HighSetting);
      buck3VselPin = 1'b0;
      tick(8);
      chk(buck3Level, buck3LowSetting);
      wr(ADDR_SLEW, 8'h00);
      buck2HighSetting = 6'h1b;
      tick(2);
      n = 2;
      while (rampBusy[0] !== 1'b0 && n < 500) begin
         tick(1);
         n++;
      end
      chk(n >= 2 * STEP, 1'b1);
      chk(buck2Level, 6'h1b);
      wr(ADDR_SLEW, 8'h07);
      deviceOn = 1'b0;
      tick(10);
   endtask
   task automatic t_follow();
      wr(ADDR_LIN_B, 8'h3f);
      tick(8);
      chk(linearBLevel, 6'h3f);
      wr(ADDR_LIN_B, 8'h40);
      tick(8);
      chk(linearBLevel, buck3LowSetting);
   endtask
   // one power cycle per order code; odd codes get slow rails
   task automatic t_seq(input logic [2:0] c);
      logic [2:0] early [8] = '{3'h3, 3'h0, 3'h4, 3'h0, 3'h0, 3'h0, 3'h0, 3'h4};
      logic [2:0] late  [8] = '{3'h3, 3'h3, 3'h7, 3'h2, 3'h3, 3'h3, 3'h2, 3'h7};
      wr(ADDR_LIN_A, {c, 5'h00});
      slow     = c[0];
      deviceOn = 1'b1;
      tick(2);
      chk(trio, early[c]);
      tick(400);
      chk(trio, late[c]);
      if (c == SEQ_AT_ON) begin
         tick(LIN_EN_DELAY_CYCLES - 410);
         chk(linearAEnable, 1'b0);
         tick(25);
         chk({linearAEnable, linearBEnable}, 2'h3);
      end
      if (c == SEQ_B1_SHORT || c == SEQ_EXT_FIRST) begin
         sw_write(1'b1, c == SEQ_B1_SHORT);
         chk({extRegEnablePin, linearBEnableBit}, c == SEQ_EXT_FIRST ? 2'h2 : 2'h1);
      end
      if (c == SEQ_EXT_SLEEP) begin
         buck3EnablePin = 1'b0;
         tick(6);
         chk(linearAEnableBit, 1'b0);
         buck3EnablePin = 1'b1;
      end
      deviceOn = 1'b0;
      tick(3);
      chk(trio, 3'h0);
      sw_write(1'b1, 1'b1);
      chk({linearAEnableBit, linearBEnableBit}, 2'h0);
   endtask
   // main sequence
   initial begin
      rstn = 1'b0;
      {undervoltageLockout, regWrEn, regRdEn, slow, swLinearWrEn} = 5'h00;
      {swLinearAEnable, swLinearBEnable, deviceOn, buck2VselPin, buck3VselPin} = 5'h00;
      {buck3EnablePin, regAddr, regWrData} = {1'b1, 16'h0000};
      {buck2LowSetting, buck2HighSetting} = {6'h04, 6'h0a};
      {buck3LowSetting, buck3HighSetting} = {6'h08, 6'h14};
      tick(10);
      rstn = 1'b1;
      t_regs();
      t_slew();
      t_follow();
      for (int c = 0; c < 8; c++)
         t_seq(3'(c));
      finish_test();
   end
   // watchdog well beyond the roughly 6500 cycles the tests need
   initial begin
      repeat (30000) @(posedge ref_clk);
      errors++;
      finish_test();
   end
endmodule
bind regulator_slew_and_ldo_sequencer seq_properties #(.EXT_DELAY(EXT_DELAY)) chk (.*);
